// ==== hw/prsc_top.v ====
// Purpose: reset, power-down, strap capture for a dual-port transceiver
// Assumes: all pins synchronous to clk_i, APB register access
// Notes:   strap pins sampled while the qualified reset is held
`timescale 1ns/1ps
`default_nettype none
`include "prsc_defs.vh"
module prsc_top #(
  parameter RST_MIN_CYC = `PRSC_RST_MIN_CYC,
  parameter RST_CNT_W   = 8
) (
  input  wire        clk_i,
  input  wire        sys_rst_i,
  // reset and test reset pins
  input  wire        reset_pin_n_i,
  input  wire        test_rst_n_i,
  output wire        test_logic_rst_o,
  // strap pins
  input  wire        mgmt_addr_strap_bit1_i,
  input  wire        mgmt_addr_strap_bit2_i,
  input  wire        mgmt_addr_strap_bit3_i,
  input  wire        mgmt_addr_strap_bit4_i,
  input  wire        port_a_fiber_strap_i,
  input  wire        port_b_fiber_strap_i,
  // per-port sleep / interrupt pins, open drain
  input  wire        port_a_sleep_or_irq_pin_i,
  output wire        port_a_sleep_or_irq_pin_o,
  output wire        port_a_sleep_or_irq_pin_oe_o,
  input  wire        port_b_sleep_or_irq_pin_i,
  output wire        port_b_sleep_or_irq_pin_o,
  output wire        port_b_sleep_or_irq_pin_oe_o,
  // per-port interrupt conditions from the port cores
  input  wire        port_a_irq_cond_i,
  input  wire        port_b_irq_cond_i,
  // configuration outputs
  output wire        core_reset_o,
  output wire        strap_sample_o,
  output wire [4:0]  port_a_mgmt_addr_o,
  output wire [4:0]  port_b_mgmt_addr_o,
  output wire        port_a_fiber_mode_o,
  output wire        port_b_fiber_mode_o,
  output wire        port_a_power_down_o,
  output wire        port_b_power_down_o,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire        irq_o
);

  // states of the reset sequencer, one-hot
  localparam ST_RUN     = 3'b001;
  localparam ST_SAMPLE  = 3'b010;
  localparam ST_RELEASE = 3'b100;

  // address decoder, used for write and read paths
  function sel_off;
    input [11:0] addr;
    input [11:0] off;
    begin
      sel_off = (addr == off);
    end
  endfunction

  wire        rst_req;
  wire        rst_qual;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [3:0]  addr_strap_reg;
  reg  [1:0]  fiber_strap_reg;
  reg  [1:0]  pin_mode_reg;
  reg  [`PRSC_EV_W-1:0] irq_stat_reg;
  reg  [`PRSC_EV_W-1:0] irq_mask_reg;
  reg  [1:0]  sleep_reg;
  reg  [1:0]  test_rst_reg;
  reg  [31:0] prdata_reg;
  reg  [`PRSC_EV_W-1:0] ev_set;
  wire        soft_rst;
  wire        wr_en;
  wire        rd_en;
  wire [1:0]  pin_in;
  wire [1:0]  irq_cond;
  wire [3:0]  addr_pins;
  wire [1:0]  fiber_pins;
  wire [7:0]  xcvr_ctrl;

  assign soft_rst   = sys_rst_i;
  assign pin_in     = {port_b_sleep_or_irq_pin_i, port_a_sleep_or_irq_pin_i};
  assign irq_cond   = {port_b_irq_cond_i, port_a_irq_cond_i};
  assign addr_pins  = {mgmt_addr_strap_bit4_i, mgmt_addr_strap_bit3_i,
                       mgmt_addr_strap_bit2_i, mgmt_addr_strap_bit1_i};
  assign fiber_pins = {port_b_fiber_strap_i, port_a_fiber_strap_i};

  // minimum-low-time qualifier on the reset pin
  prsc_reset_filter #(
    .MIN_CYC (RST_MIN_CYC),
    .CNT_W   (RST_CNT_W)
  ) u_filter (
    .clk_i         (clk_i),
    .sys_rst_i     (soft_rst),
    .reset_pin_n_i (reset_pin_n_i),
    .reset_req_o   (rst_req),
    .reset_qual_o  (rst_qual)
  );

  // sequencer: sample while qualified reset held, then one release cycle
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (rst_qual)
          state_next = ST_SAMPLE;
      end
      ST_SAMPLE: begin
        if (!rst_req)
          state_next = ST_RELEASE;
      end
      ST_RELEASE: begin
        state_next = ST_RUN;
      end
      default: begin
        state_next = ST_RUN;
      end
    endcase
  end

  always @(posedge clk_i) begin
    if (soft_rst)
      state_reg <= ST_RUN;
    else
      state_reg <= state_next;
  end

  // a short glitch never reaches the sampling state, so straps stay put
  wire in_reset = (state_reg == ST_SAMPLE);
  assign core_reset_o   = in_reset | (state_reg == ST_RELEASE);
  assign strap_sample_o = in_reset;

  // strap capture: each sampled cycle overwrites, last one before release
  // wins; outside reset the pins are functional and ignored here
  always @(posedge clk_i) begin
    if (soft_rst) begin
      addr_strap_reg  <= 4'h0;
      fiber_strap_reg <= 2'h0;
    end else if (in_reset && rst_req) begin    // pins go live on release
      addr_strap_reg  <= addr_pins;
      fiber_strap_reg <= fiber_pins;
    end
  end

  // management addresses: bit 0 names the port
  assign port_a_mgmt_addr_o = {addr_strap_reg, 1'b0};
  assign port_b_mgmt_addr_o = {addr_strap_reg, 1'b1};
  assign port_a_fiber_mode_o = fiber_strap_reg[0];
  assign port_b_fiber_mode_o = fiber_strap_reg[1];

  assign xcvr_ctrl = {2'h0, fiber_strap_reg, addr_strap_reg};

  // APB: zero wait states, unmapped reads give zero with an error
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  wire mapped = sel_off(paddr, `PRSC_OFF_XCVR_CTRL) |
                sel_off(paddr, `PRSC_OFF_PIN_MODE) |
                sel_off(paddr, `PRSC_OFF_IRQ_STAT) |
                sel_off(paddr, `PRSC_OFF_IRQ_MASK) |
                sel_off(paddr, `PRSC_OFF_STATUS) |
                sel_off(paddr, `PRSC_OFF_EVT_SET);
  assign pslverr = psel & penable & ~mapped;

  // pin role and mask registers; every hardware reset restores defaults
  always @(posedge clk_i) begin
    if (soft_rst || core_reset_o) begin
      pin_mode_reg <= `PRSC_PIN_MODE_RST;
      irq_mask_reg <= `PRSC_IRQ_MASK_RST;
    end else if (wr_en) begin
      if (sel_off(paddr, `PRSC_OFF_PIN_MODE))
        pin_mode_reg <= pwdata[1:0];
      if (sel_off(paddr, `PRSC_OFF_IRQ_MASK))
        irq_mask_reg <= pwdata[`PRSC_EV_W-1:0];
    end
  end

  // power-down request: low pin while in power-down role
  always @(posedge clk_i) begin
    if (soft_rst || core_reset_o)
      sleep_reg <= 2'h0;
    else
      sleep_reg <= ~pin_in & ~pin_mode_reg;
  end
  assign port_a_power_down_o = sleep_reg[0];
  assign port_b_power_down_o = sleep_reg[1];

  // events: sleep entry/exit per port and end of reset
  always @* begin
    ev_set = {`PRSC_EV_W{1'b0}};
    ev_set[`PRSC_EV_RESET_DONE] = (state_reg == ST_RELEASE);
    ev_set[`PRSC_EV_SLEEP_A] = ~sleep_reg[0] & ~pin_in[0] & ~pin_mode_reg[0];
    ev_set[`PRSC_EV_SLEEP_B] = ~sleep_reg[1] & ~pin_in[1] & ~pin_mode_reg[1];
    ev_set[`PRSC_EV_WAKE_A]  = sleep_reg[0] & (pin_in[0] | pin_mode_reg[0]);
    ev_set[`PRSC_EV_WAKE_B]  = sleep_reg[1] & (pin_in[1] | pin_mode_reg[1]);
    if (wr_en && sel_off(paddr, `PRSC_OFF_EVT_SET))
      ev_set = ev_set | pwdata[`PRSC_EV_W-1:0];
  end

  // sticky status, write one to clear; a new event beats the clear
  // reset-done must survive the core reset so it is only cleared by sw or by sys_rst_i
  always @(posedge clk_i) begin
    if (soft_rst)
      irq_stat_reg <= {`PRSC_EV_W{1'b0}};
    else if (wr_en && sel_off(paddr, `PRSC_OFF_IRQ_STAT))
      irq_stat_reg <= (irq_stat_reg & ~pwdata[`PRSC_EV_W-1:0]) | ev_set;
    else
      irq_stat_reg <= irq_stat_reg | ev_set;
  end
  assign irq_o = |(irq_stat_reg & irq_mask_reg);

  // open drain: only ever drive low, and only in interrupt role
  wire [1:0] drive_low = pin_mode_reg & irq_cond;
  assign port_a_sleep_or_irq_pin_o    = 1'b0;
  assign port_a_sleep_or_irq_pin_oe_o = drive_low[0];
  assign port_b_sleep_or_irq_pin_o    = 1'b0;
  assign port_b_sleep_or_irq_pin_oe_o = drive_low[1];

  // test-access reset asserts with the test reset pin, releases two cycles after it
  always @(posedge clk_i) begin
    if (soft_rst)
      test_rst_reg <= 2'h3;
    else
      test_rst_reg <= {test_rst_reg[0], ~test_rst_n_i};
  end
  assign test_logic_rst_o = test_rst_reg[1] | ~test_rst_n_i;

  // read data registered in the setup phase
  always @(posedge clk_i) begin
    if (soft_rst) begin
      prdata_reg <= 32'h0;
    end else if (rd_en) begin
      prdata_reg <= 32'h0;
      if (sel_off(paddr, `PRSC_OFF_XCVR_CTRL))
        prdata_reg <= {24'h0, xcvr_ctrl};
      if (sel_off(paddr, `PRSC_OFF_PIN_MODE))
        prdata_reg <= {30'h0, pin_mode_reg};
      if (sel_off(paddr, `PRSC_OFF_IRQ_STAT))
        prdata_reg <= {27'h0, irq_stat_reg};
      if (sel_off(paddr, `PRSC_OFF_IRQ_MASK))
        prdata_reg <= {27'h0, irq_mask_reg};
      if (sel_off(paddr, `PRSC_OFF_STATUS))
        prdata_reg <= {26'h0, sleep_reg, 1'b0, core_reset_o,
                       state_reg[1], rst_qual};
    end
  end
  assign prdata = prdata_reg;

endmodule // prsc_top
`default_nettype wire

// ==== hw/prsc_defs.vh ====
// Purpose: constants for the reset, power-down and strap-capture block
// Assumes: 50 MHz system clock
// Notes:   offsets are byte addresses on the APB register bus
`ifndef PRSC_DEFS_VH
`define PRSC_DEFS_VH

// timing
`define PRSC_CLK_MHZ          50
`define PRSC_RST_MIN_NS       1000
`define PRSC_RST_MIN_CYC      ((`PRSC_RST_MIN_NS * `PRSC_CLK_MHZ + 999) / 1000)

// register byte offsets
`define PRSC_OFF_XCVR_CTRL    12'h000
`define PRSC_OFF_PIN_MODE     12'h004
`define PRSC_OFF_IRQ_STAT     12'h008
`define PRSC_OFF_IRQ_MASK     12'h00c
`define PRSC_OFF_STATUS       12'h010
`define PRSC_OFF_EVT_SET      12'h014

// transceiver control register fields
`define PRSC_XC_ADDR_LSB      0
`define PRSC_XC_ADDR_MSB      3
`define PRSC_XC_FIBER_A       4
`define PRSC_XC_FIBER_B       5

// pin mode register: bit per port, 1 = interrupt role
`define PRSC_PM_IRQ_A         0
`define PRSC_PM_IRQ_B         1
`define PRSC_PIN_MODE_RST     2'h0

// interrupt status bits
`define PRSC_EV_RESET_DONE    0
`define PRSC_EV_SLEEP_A       1
`define PRSC_EV_SLEEP_B       2
`define PRSC_EV_WAKE_A        3
`define PRSC_EV_WAKE_B        4
`define PRSC_EV_W             5
`define PRSC_IRQ_MASK_RST     5'h00

`endif

// ==== hw/prsc_reset_filter.v ====
// Purpose: qualifies the active-low reset pin by a minimum low time
// Assumes: pin already synchronous to clk_i
// Notes:   pulse is not stretched, reset_req_o drops as soon as the pin returns high, reset_qual_o on the next clock edge
`timescale 1ns/1ps
`default_nettype none
module prsc_reset_filter #(
  parameter MIN_CYC = 50,
  parameter CNT_W   = 8
) (
  input  wire clk_i,
  input  wire sys_rst_i,
  input  wire reset_pin_n_i,
  output wire reset_req_o,
  output wire reset_qual_o
);

  reg [CNT_W-1:0] low_cnt_reg;
  reg             qual_reg;

  // count cycles of low pin; qualify once the minimum is reached
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      low_cnt_reg <= {CNT_W{1'b0}};
      qual_reg    <= 1'b0;
    end else if (reset_pin_n_i) begin
      low_cnt_reg <= {CNT_W{1'b0}};
      qual_reg    <= 1'b0;
    end else if (low_cnt_reg != MIN_CYC[CNT_W-1:0]) begin
      low_cnt_reg <= low_cnt_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end else begin
      qual_reg    <= 1'b1;
    end
  end

  assign reset_req_o  = ~reset_pin_n_i;
  assign reset_qual_o = qual_reg;

endmodule // prsc_reset_filter
`default_nettype wire

// ==== bench/prsc_top_sva.sv ====
// Purpose: concurrent checks on the reset and strap capture block
// Assumes: one clock domain, sync active-high system reset
// Notes:   low_cnt counts consecutive low samples of the reset pin
`timescale 1ns/1ps
`default_nettype none
module prsc_top_sva #(
  parameter RST_MIN_CYC = 50
) (
  input wire logic       clk_i,
  input wire logic       sys_rst_i,
  input wire logic       reset_pin_n_i,
  input wire logic       test_rst_n_i,
  input wire logic       test_logic_rst_o,
  input wire logic       mgmt_addr_strap_bit1_i,
  input wire logic       mgmt_addr_strap_bit2_i,
  input wire logic       mgmt_addr_strap_bit3_i,
  input wire logic       mgmt_addr_strap_bit4_i,
  input wire logic       port_a_fiber_strap_i,
  input wire logic       port_b_fiber_strap_i,
  input wire logic       port_a_sleep_or_irq_pin_i,
  input wire logic       port_a_sleep_or_irq_pin_oe_o,
  input wire logic       port_a_irq_cond_i,
  input wire logic       core_reset_o,
  input wire logic       strap_sample_o,
  input wire logic [4:0] port_a_mgmt_addr_o,
  input wire logic [4:0] port_b_mgmt_addr_o,
  input wire logic       port_a_fiber_mode_o,
  input wire logic       port_b_fiber_mode_o,
  input wire logic       port_a_power_down_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [7:0] low_cnt;
  wire  [3:0] adr = {mgmt_addr_strap_bit4_i, mgmt_addr_strap_bit3_i,
                     mgmt_addr_strap_bit2_i, mgmt_addr_strap_bit1_i};
  // saturates so a long hold cannot wrap back into the short range
  always @(posedge clk_i) begin
    if (sys_rst_i || reset_pin_n_i)
      low_cnt <= 8'h00;
    else if (low_cnt != 8'hff)
      low_cnt <= low_cnt + 8'h01;
  end
  property p_qual; low_cnt == RST_MIN_CYC + 3 |-> strap_sample_o; endproperty
  a_qual: assert property (p_qual) else $error("long low not taken");
  property p_short; low_cnt != 0 && low_cnt < RST_MIN_CYC |->
    !strap_sample_o; endproperty
  a_short: assert property (p_short) else $error("short low taken");
  property p_in_rst; strap_sample_o |-> !$past(reset_pin_n_i); endproperty
  a_in_rst: assert property (p_in_rst) else $error("sample out of reset");
  property p_cap; strap_sample_o && !reset_pin_n_i |=>
    port_a_mgmt_addr_o[4:1] == $past(adr)
    && port_a_fiber_mode_o == $past(port_a_fiber_strap_i)
    && port_b_fiber_mode_o == $past(port_b_fiber_strap_i); endproperty
  a_cap: assert property (p_cap) else $error("strap not captured");
  property p_hold; !strap_sample_o |=> $stable({port_a_mgmt_addr_o,
    port_b_mgmt_addr_o, port_a_fiber_mode_o, port_b_fiber_mode_o});
  endproperty
  a_hold: assert property (p_hold) else $error("strap value moved");
  property p_pair; port_b_mgmt_addr_o == {port_a_mgmt_addr_o[4:1], 1'b1}
    && !port_a_mgmt_addr_o[0]; endproperty
  a_pair: assert property (p_pair) else $error("port address pair");
  property p_oe; port_a_sleep_or_irq_pin_oe_o |-> port_a_irq_cond_i;
  endproperty
  a_oe: assert property (p_oe) else $error("pin pulled without cause");
  property p_pd_cause; port_a_power_down_o |->
    !$past(port_a_sleep_or_irq_pin_i); endproperty
  a_pd_cause: assert property (p_pd_cause) else $error("sleep w/o pin");
  property p_pd_on; (!core_reset_o && !port_a_sleep_or_irq_pin_i
    && !port_a_sleep_or_irq_pin_oe_o) [*2] |-> port_a_power_down_o;
  endproperty
  a_pd_on: assert property (p_pd_on) else $error("sleep not entered");
  property p_trst; !test_rst_n_i |-> test_logic_rst_o; endproperty
  a_trst: assert property (p_trst) else $error("test logic not reset");
  c_sample: cover property (strap_sample_o);
  c_sleep: cover property (port_a_power_down_o);
  c_irq: cover property (port_a_sleep_or_irq_pin_oe_o);
endmodule // prsc_top_sva
bind prsc_top prsc_top_sva #(.RST_MIN_CYC(RST_MIN_CYC)) u_sva (.*);
`default_nettype wire

// ==== bench/prsc_board.sv ====
// Purpose: host reset driver, strap resistors and open-drain pins
// Assumes: host requests are synchronous to clk_i
// Notes:   strap pins carry live traffic once reset is released
`timescale 1ns/1ps
`default_nettype none
module prsc_board (
  input  wire logic       clk_i,
  input  wire logic       hold_i,
  input  wire logic [5:0] strap_i,
  input  wire logic       sleep_a_i,
  input  wire logic       sleep_b_i,
  input  wire logic       oe_a_i,
  input  wire logic       oe_b_i,
  output logic            rst_n_o,
  output logic      [5:0] pins_o,
  output logic            pin_a_o,
  output logic            pin_b_o
);
  logic [5:0] cnt_reg = 6'h00;
  // traffic pattern differs from the strap level except when cnt_reg is 6'h3f
  always @(posedge clk_i) cnt_reg <= cnt_reg + 6'h01;
  assign rst_n_o = !hold_i;
  // zero strap means no resistor fitted, pull-down wins
  assign pins_o = rst_n_o ? (cnt_reg ^ ~strap_i) : strap_i;
  // open drain with pull-up, host or device may pull low
  assign pin_a_o = !(oe_a_i || sleep_a_i);
  assign pin_b_o = !(oe_b_i || sleep_b_i);
endmodule // prsc_board
`default_nettype wire

// ==== bench/testbench.sv ====
// Purpose: directed bench for reset, strap capture and sleep pins
// Assumes: board model drives reset pin, straps and open-drain pins
// Notes:   qualifying count shortened to keep the run brief
`timescale 1ns/1ps
`default_nettype none
`include "prsc_defs.vh"
module testbench;
  localparam int MIN = 3;
  logic        clk_i = 1'h0, sys_rst_i = 1'h1, test_rst_n_i = 1'h1;
  logic        port_a_irq_cond_i = 1'h0, port_b_irq_cond_i = 1'h0;
  logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err;
  logic        hold = 1'h0, sl_a = 1'h0, sl_b = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, q;
  logic [5:0]  strap = 6'h00;
  logic [5:0]  pat [4] = '{6'h00, 6'h3f, 6'h15, 6'h2a};
  int          n_fail = 0, n_compared = 0, cyc = 0;
  wire         reset_pin_n_i, port_a_sleep_or_irq_pin_i;
  wire         port_b_sleep_or_irq_pin_i, mgmt_addr_strap_bit1_i;
  wire         mgmt_addr_strap_bit2_i, mgmt_addr_strap_bit3_i;
  wire         mgmt_addr_strap_bit4_i, port_a_fiber_strap_i;
  wire         port_b_fiber_strap_i, test_logic_rst_o, core_reset_o;
  wire         port_a_sleep_or_irq_pin_o, port_b_sleep_or_irq_pin_o;
  wire         port_a_sleep_or_irq_pin_oe_o, port_b_sleep_or_irq_pin_oe_o;
  wire         strap_sample_o, port_a_fiber_mode_o, port_b_fiber_mode_o;
  wire         port_a_power_down_o, port_b_power_down_o;
  wire         pready, pslverr, irq_o;
  wire  [4:0]  port_a_mgmt_addr_o, port_b_mgmt_addr_o;
  wire  [31:0] prdata;
  initial forever #10 clk_i = ~clk_i;
  prsc_board BRD (.clk_i(clk_i), .hold_i(hold), .strap_i(strap),
    .sleep_a_i(sl_a), .sleep_b_i(sl_b),
    .oe_a_i(port_a_sleep_or_irq_pin_oe_o),
    .oe_b_i(port_b_sleep_or_irq_pin_oe_o), .rst_n_o(reset_pin_n_i),
    .pins_o({port_b_fiber_strap_i, port_a_fiber_strap_i,
      mgmt_addr_strap_bit4_i, mgmt_addr_strap_bit3_i,
      mgmt_addr_strap_bit2_i, mgmt_addr_strap_bit1_i}),
    .pin_a_o(port_a_sleep_or_irq_pin_i), .pin_b_o(port_b_sleep_or_irq_pin_i));
  prsc_top #(.RST_MIN_CYC(MIN)) DUT (.*);
  task automatic end_of_test;
    if (n_fail == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one apb transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'h1;
    do @(posedge clk_i); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_i);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    chk(nm, q, e);
  endtask
  // host holds the reset pin low for n cycles
  task automatic pin_rst(input int n);
    hold <= 1'h1;
    repeat (n) @(posedge clk_i);
    hold <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask
  // hang guard, the whole sequence needs about 130 cycles
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_of_test;
    end
  end
  initial begin
    repeat (8) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    @(posedge clk_i);
    rd("pin mode", `PRSC_OFF_PIN_MODE, 32'h0);
    rd("irq mask", `PRSC_OFF_IRQ_MASK, 32'h0);
    rd("unmapped", 12'h018, 32'h0);
    chk("slverr", err, 32'h1);
    foreach (pat[i]) begin
      strap <= pat[i];
      pin_rst(MIN + 4);
      chk("addr a", port_a_mgmt_addr_o, {pat[i][3:0], 1'h0});
      chk("addr b", port_b_mgmt_addr_o, {pat[i][3:0], 1'h1});
      chk("fiber", {port_b_fiber_mode_o, port_a_fiber_mode_o}, pat[i][5:4]);
      rd("xcvr", `PRSC_OFF_XCVR_CTRL, pat[i]);
    end
    strap <= 6'h3f;
    pin_rst(MIN - 1);
    rd("xcvr short", `PRSC_OFF_XCVR_CTRL, 32'h2a);
    rd("reset done", `PRSC_OFF_IRQ_STAT, 32'h1);
    apb(1'h1, `PRSC_OFF_IRQ_STAT, 32'h1);
    sl_a <= 1'h1;
    sl_b <= 1'h1;
    repeat (3) @(posedge clk_i);
    chk("sleep", {port_b_power_down_o, port_a_power_down_o}, 32'h3);
    rd("sleep stat", `PRSC_OFF_IRQ_STAT, 32'h6);
    apb(1'h1, `PRSC_OFF_IRQ_MASK, 32'h2);
    chk("irq on", irq_o, 32'h1);
    apb(1'h1, `PRSC_OFF_IRQ_STAT, 32'h2);
    chk("irq clr", irq_o, 32'h0);
    apb(1'h1, `PRSC_OFF_IRQ_MASK, 32'h4);
    chk("irq b", irq_o, 32'h1);
    apb(1'h1, `PRSC_OFF_IRQ_MASK, 32'h0);
    chk("irq mask", irq_o, 32'h0);
    sl_a <= 1'h0;
    sl_b <= 1'h0;
    apb(1'h1, `PRSC_OFF_PIN_MODE, 32'h3);
    port_a_irq_cond_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    chk("pin pull", {port_a_sleep_or_irq_pin_i, port_a_sleep_or_irq_pin_oe_o,
      port_a_power_down_o}, 32'h2);
    pin_rst(MIN + 4);
    rd("mode rst", `PRSC_OFF_PIN_MODE, 32'h0);
    chk("pin free", port_a_sleep_or_irq_pin_oe_o, 32'h0);
    port_a_irq_cond_i <= 1'h0;
    test_rst_n_i <= 1'h0;
    repeat (2) @(posedge clk_i);
    chk("test rst", test_logic_rst_o, 32'h1);
    test_rst_n_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    chk("test run", test_logic_rst_o, 32'h0);
    end_of_test;
  end
endmodule // testbench
`default_nettype wire
